// ===== rrb_pkg.sv
// Constants and types shared by both ends of the resource register bank
package rrb_pkg;
  // Register indices in the private resource space
  localparam logic [3:0] RRB_A_IN = 4'h0;
  localparam logic [3:0] RRB_A_IP = 4'h1;
  localparam logic [3:0] RRB_A_IUS = 4'h2;
  localparam logic [3:0] RRB_A_OUT = 4'h3;
  localparam logic [3:0] RRB_A_IE = 4'h4;
  localparam logic [3:0] RRB_A_DMAE = 4'h5;
  localparam logic [3:0] RRB_A_DMAEX = 4'h6;
  localparam logic [3:0] RRB_A_VRAM = 4'h7;
  localparam logic [3:0] RRB_A_PINSEL = 4'h8;
  // Highest index that has bit addresses
  localparam logic [3:0] RRB_A_BIT_LAST = 4'h6;
  // Video control field layout
  localparam int RRB_V_W = 7;
  localparam int RRB_V_GRP_LSB = 5;
  localparam int RRB_V_DSFCAS = 4;
  localparam logic [6:0] RRB_V_ONESHOT = 7'h0F;
  localparam logic [6:0] RRB_V_RESET = 7'h60;
  // Reset values of the bit registers
  localparam logic [7:0] RRB_IN_RESET = 8'hFF;
  localparam logic [7:0] RRB_ZERO8 = 8'h00;
  // Channel page size and its last byte offset
  localparam int RRB_PAGE_BYTES = 1024;
  localparam logic [9:0] RRB_PAGE_LAST = 10'(RRB_PAGE_BYTES - 1);
  // Staging states of the hidden video register
  typedef enum logic [1:0] {
    RRB_VS_IDLE = 2'b00,
    RRB_VS_POST = 2'b01,
    RRB_VS_LOCK = 2'b11,
    RRB_VS_LPEND = 2'b10
  } rrb_vstate_e;
endpackage

// ===== rrb_if.sv
// Link between the core-side logic and the resource register bank
`timescale 1ns/100ps
interface rrb_if;
  // Register access
  logic [3:0] req_addr;
  logic req_bit;
  logic [2:0] req_idx;
  logic [31:0] req_wdata;
  logic req_we;
  logic req_re;
  logic [31:0] rdata;
  // Consumers and interrupt events
  logic [7:0] vpu_consume;
  logic [7:0] dma_ack;
  logic sw_int;
  logic [2:0] sw_int_lvl;
  logic vec_exec;
  logic [2:0] vec_lvl;
  logic reti;
  // Channel transfer progress
  logic dma_xfer;
  logic [2:0] dma_ch;
  logic [9:0] dma_addr;
  // Memory interface status
  logic posted_busy;
  logic mem_done;
  logic mem_core;
  logic [1:0] mem_grp;
  // Requests and staged video control
  logic irq_req;
  logic [2:0] irq_lvl;
  logic [7:0] dma_req;
  logic [1:0] vram_grp;
  logic [4:0] vram_bits;
  logic vram_locked;
  modport dev (
    input req_addr, req_bit, req_idx, req_wdata, req_we, req_re,
    input vpu_consume, dma_ack, sw_int, sw_int_lvl, vec_exec, vec_lvl,
    input reti, dma_xfer, dma_ch, dma_addr, posted_busy, mem_done,
    input mem_core, mem_grp,
    output rdata, irq_req, irq_lvl, dma_req, vram_grp, vram_bits,
    output vram_locked
  );
  modport host (
    output req_addr, req_bit, req_idx, req_wdata, req_we, req_re,
    output vpu_consume, dma_ack, sw_int, sw_int_lvl, vec_exec, vec_lvl,
    output reti, dma_xfer, dma_ch, dma_addr, posted_busy, mem_done,
    output mem_core, mem_grp,
    input rdata, irq_req, irq_lvl, dma_req, vram_grp, vram_bits,
    input vram_locked
  );
endinterface

// ===== rrb_host.sv
// Core-side end: register port and event sources toward the bank
`timescale 1ns/100ps
module rrb_host import rrb_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Software register port
  input wire logic [3:0] usr_addr,
  input wire logic usr_bit,
  input wire logic [2:0] usr_idx,
  input wire logic [31:0] usr_wdata,
  input wire logic usr_we,
  input wire logic usr_re,
  output logic [31:0] usr_rdata,
  output logic usr_refused,
  // Bus activity seen by software
  input wire logic usr_bus_busy,
  // Event sources
  input wire logic [7:0] usr_vpu_consume,
  input wire logic [7:0] usr_dma_ack,
  input wire logic usr_sw_int,
  input wire logic [2:0] usr_sw_int_lvl,
  input wire logic usr_vec_exec,
  input wire logic [2:0] usr_vec_lvl,
  input wire logic usr_reti,
  input wire logic usr_dma_xfer,
  input wire logic [2:0] usr_dma_ch,
  input wire logic [9:0] usr_dma_addr,
  input wire logic usr_posted_busy,
  input wire logic usr_mem_done,
  input wire logic usr_mem_core,
  input wire logic [1:0] usr_mem_grp,
  // Status from the bank
  output logic usr_irq_req,
  output logic [2:0] usr_irq_lvl,
  output logic [7:0] usr_dma_req,
  // Link to the bank
  rrb_if.host bus
);
  logic cfg_hit;
  logic refused_d;
  logic refused_q;

  // Video control write while the bus is active is held back
  assign cfg_hit = usr_we && (usr_addr == RRB_A_VRAM) && usr_bus_busy;

  // Register requests in the private space
  assign bus.req_addr = usr_addr;
  assign bus.req_bit = usr_bit;
  assign bus.req_idx = usr_idx;
  assign bus.req_wdata = usr_wdata;
  assign bus.req_we = usr_we && !cfg_hit;
  assign bus.req_re = usr_re;
  assign usr_rdata = bus.rdata;

  // Event forwarding; software interrupt raises a pending bit
  assign bus.vpu_consume = usr_vpu_consume;
  assign bus.dma_ack = usr_dma_ack;
  assign bus.sw_int = usr_sw_int;
  assign bus.sw_int_lvl = usr_sw_int_lvl;
  assign bus.vec_exec = usr_vec_exec;
  assign bus.vec_lvl = usr_vec_lvl;
  assign bus.reti = usr_reti;
  assign bus.dma_xfer = usr_dma_xfer;
  assign bus.dma_ch = usr_dma_ch;
  assign bus.dma_addr = usr_dma_addr;
  assign bus.posted_busy = usr_posted_busy;
  assign bus.mem_done = usr_mem_done;
  assign bus.mem_core = usr_mem_core;
  assign bus.mem_grp = usr_mem_grp;

  // Status back to the user side
  assign usr_irq_req = bus.irq_req;
  assign usr_irq_lvl = bus.irq_lvl;
  assign usr_dma_req = bus.dma_req;

  // Refusal flag for a held-back write
  always_comb
  begin
    refused_d = cfg_hit;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      refused_q <= 1'b0;
    else
      refused_q <= refused_d;
  end

  assign usr_refused = refused_q;
endmodule

// ===== rrb_device.sv
// Resource register bank: bit I/O, interrupt, channel and video control
//
// Overview of operation
// - Registers live in private space, word or bit access
// - Unmapped areas read zero, ignore writes
// - Input latch bits stay zero until consumed
// - Latch source is pins or strobed AD lines
// - Level 0 highest, level 7 lowest priority
// - Latch bit or software interrupt sets pending bit
// - Pending plus enable ends zero persistence
// - Vector execution sets in-service, clears pending
// - Return clears highest-priority in-service bit only
// - In-service plus enable ends zero persistence
// - Output bits drive pins and AD when row idle
// - Enabled zero latch bit raises pending interrupt
// - Channel-enabled zero bit requests transfer, then reset
// - Auto-disable clears channel enable at page end
// - Video bits staged in hidden register with group
// - Hidden register locked until core video access
// - Unlocked write copies now or after posted write
// - Locked write waits, overwritable, copied after access
// - Only core accesses consume or reload hidden register
// - Copy clears the four one-shot row bits
// - Video control resets to group 3, bits zero
// - Software keeps row precharge three cycles or more
// - Software stops bus activity before timing changes
//
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
module rrb_device import rrb_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Bit input pins and strobes
  input wire logic [7:0] in_pins,
  input wire logic ras_n,
  input wire logic cas_n,
  // Low address/data lines, two-way
  input wire logic [7:0] ad_in,
  output logic [7:0] ad_out,
  output logic ad_oe,
  // Bit output pins
  output logic [7:0] out_pins,
  // Link to the core side
  rrb_if.dev bus
);
  // First set bit from level 0 upward, with a found flag
  function automatic logic [3:0] rrb_first(input logic [7:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 7; i >= 0; i--)
    begin
      if (v[i])
        r = {1'b1, 3'(i)};
    end
    return r;
  endfunction

  // Word or single-bit software write on top of hardware value
  function automatic logic [7:0] rrb_sw8(input logic [7:0] hw,
    input logic hit, input logic bitop, input logic [2:0] idx,
    input logic [31:0] wd);
    logic [7:0] r;
    r = hw;
    if (hit && bitop)
      r[idx] = wd[0];
    else if (hit)
      r = wd[7:0];
    return r;
  endfunction

  logic [7:0] in_q, in_d, ip_q, ip_d, ius_q, ius_d, out_q, out_d;
  logic [7:0] ie_q, ie_d, dmae_q, dmae_d, dmaex_q, dmaex_d;
  logic pinsel_q, pinsel_d;
  logic [31:0] rdata_q, rdata_d;
  logic irq_q, irq_d;
  logic [2:0] irql_q, irql_d;
  logic [6:0] vctl_q, vctl_d, hid_q, hid_d;
  rrb_vstate_e vs_q, vs_d;
  logic [7:0] samp, persist, raise, swint, vset, rclr, aclr, dack;
  logic [3:0] pfirst, sfirst;
  logic [7:0] rsel;
  logic bitok, hit_in, hit_ip, hit_ius, hit_out, hit_ie, hit_dmae;
  logic hit_dmaex, vwr, acc, copy;

  // Write decode; bit writes only where bit addresses exist
  assign bitok = !bus.req_bit || (bus.req_addr <= RRB_A_BIT_LAST);
  assign hit_in = bus.req_we && bitok && bus.req_addr == RRB_A_IN;
  assign hit_ip = bus.req_we && bitok && bus.req_addr == RRB_A_IP;
  assign hit_ius = bus.req_we && bitok && bus.req_addr == RRB_A_IUS;
  assign hit_out = bus.req_we && bitok && bus.req_addr == RRB_A_OUT;
  assign hit_ie = bus.req_we && bitok && bus.req_addr == RRB_A_IE;
  assign hit_dmae = bus.req_we && bitok && bus.req_addr == RRB_A_DMAE;
  assign hit_dmaex = bus.req_we && bitok && bus.req_addr == RRB_A_DMAEX;
  assign vwr = bus.req_we && !bus.req_bit && bus.req_addr == RRB_A_VRAM;

  // Priority scan of pending and in-service bits
  assign pfirst = rrb_first(ip_q);
  assign sfirst = rrb_first(ius_q);

  // Bit I/O, interrupt and channel next values
  always_comb
  begin
    // Latch source: pins, or AD while row low and column high
    if (pinsel_q)
      samp = in_pins;
    else if (!ras_n && cas_n)
      samp = ad_in;
    else
      samp = in_q;
    persist = ~((ip_q & ie_q) | (ius_q & ie_q));
    dack = bus.dma_ack & dmae_q;
    in_d = samp & (in_q | ~persist);
    in_d = in_d | bus.vpu_consume | dack;
    in_d = rrb_sw8(in_d, hit_in, bus.req_bit, bus.req_idx,
      bus.req_wdata);
    raise = ~in_q & ie_q & ~dmae_q;
    swint = bus.sw_int ? (8'h01 << bus.sw_int_lvl) : RRB_ZERO8;
    vset = bus.vec_exec ? (8'h01 << bus.vec_lvl) : RRB_ZERO8;
    rclr = (bus.reti && sfirst[3]) ? (8'h01 << sfirst[2:0])
      : RRB_ZERO8;
    // Hardware sets are applied last so they win over clears
    ip_d = rrb_sw8(ip_q & ~vset, hit_ip, bus.req_bit, bus.req_idx,
      bus.req_wdata);
    ip_d = ip_d | raise | swint;
    ius_d = rrb_sw8(ius_q & ~rclr, hit_ius, bus.req_bit, bus.req_idx,
      bus.req_wdata);
    ius_d = ius_d | vset;
    out_d = rrb_sw8(out_q, hit_out, bus.req_bit, bus.req_idx,
      bus.req_wdata);
    ie_d = rrb_sw8(ie_q, hit_ie, bus.req_bit, bus.req_idx,
      bus.req_wdata);
    aclr = (bus.dma_xfer && bus.dma_addr == RRB_PAGE_LAST)
      ? ((8'h01 << bus.dma_ch) & dmaex_q) : RRB_ZERO8;
    dmae_d = rrb_sw8(dmae_q & ~aclr, hit_dmae, bus.req_bit,
      bus.req_idx, bus.req_wdata);
    dmaex_d = rrb_sw8(dmaex_q, hit_dmaex, bus.req_bit, bus.req_idx,
      bus.req_wdata);
    pinsel_d = pinsel_q;
    if (bus.req_we && !bus.req_bit && bus.req_addr == RRB_A_PINSEL)
      pinsel_d = bus.req_wdata[0];
    // Interrupt request when top pending beats top in-service
    irq_d = pfirst[3] && (!sfirst[3] || pfirst[2:0] < sfirst[2:0]);
    irql_d = pfirst[2:0];
  end

  // Read data, one cycle after the strobe; unmapped reads zero
  always_comb
  begin
    case (bus.req_addr)
      RRB_A_IN: rsel = in_q;
      RRB_A_IP: rsel = ip_q;
      RRB_A_IUS: rsel = ius_q;
      RRB_A_OUT: rsel = out_q;
      RRB_A_IE: rsel = ie_q;
      RRB_A_DMAE: rsel = dmae_q;
      RRB_A_DMAEX: rsel = dmaex_q;
      RRB_A_VRAM: rsel = {1'b0, vctl_q};
      RRB_A_PINSEL: rsel = {7'h00, pinsel_q};
      default: rsel = RRB_ZERO8;
    endcase
    rdata_d = 32'h00000000;
    if (bus.req_re && bus.req_bit && bitok)
      rdata_d = {31'h00000000, rsel[bus.req_idx]};
    else if (bus.req_re && !bus.req_bit)
      rdata_d = {24'h000000, rsel};
  end

  // Video control staging through the hidden register
  always_comb
  begin
    acc = bus.mem_done && bus.mem_core
      && bus.mem_grp == hid_q[RRB_V_GRP_LSB +: 2];
    copy = 1'b0;
    vs_d = vs_q;
    case (vs_q)
      RRB_VS_IDLE:
      begin
        if (vwr)
          vs_d = RRB_VS_POST;
      end
      RRB_VS_POST:
      begin
        if (!bus.posted_busy)
        begin
          copy = 1'b1;
          vs_d = vwr ? RRB_VS_LPEND : RRB_VS_LOCK;
        end
      end
      RRB_VS_LOCK:
      begin
        if (vwr)
          vs_d = RRB_VS_LPEND;
        else if (acc)
          vs_d = RRB_VS_IDLE;
      end
      RRB_VS_LPEND:
      begin
        if (acc)
        begin
          copy = 1'b1;
          vs_d = vwr ? RRB_VS_LPEND : RRB_VS_LOCK;
        end
      end
      default: vs_d = RRB_VS_IDLE;
    endcase
    hid_d = copy ? vctl_q : hid_q;
    if (vwr)
      vctl_d = bus.req_wdata[RRB_V_W-1:0];
    else if (copy)
      vctl_d = vctl_q & ~RRB_V_ONESHOT;
    else
      vctl_d = vctl_q;
  end

  // State registers
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      in_q <= RRB_IN_RESET;
      ip_q <= RRB_ZERO8;
      ius_q <= RRB_ZERO8;
      out_q <= RRB_ZERO8;
      ie_q <= RRB_ZERO8;
      dmae_q <= RRB_ZERO8;
      dmaex_q <= RRB_ZERO8;
      pinsel_q <= 1'b0;
      rdata_q <= 32'h00000000;
      irq_q <= 1'b0;
      irql_q <= 3'h0;
      vctl_q <= RRB_V_RESET;
      hid_q <= RRB_V_RESET;
      vs_q <= RRB_VS_IDLE;
    end
    else
    begin
      in_q <= in_d;
      ip_q <= ip_d;
      ius_q <= ius_d;
      out_q <= out_d;
      ie_q <= ie_d;
      dmae_q <= dmae_d;
      dmaex_q <= dmaex_d;
      pinsel_q <= pinsel_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
      irql_q <= irql_d;
      vctl_q <= vctl_d;
      hid_q <= hid_d;
      vs_q <= vs_d;
    end
  end

  // Outputs to pins and to the core side
  assign out_pins = out_q;
  assign ad_out = out_q;
  assign ad_oe = ras_n;
  assign bus.rdata = rdata_q;
  assign bus.irq_req = irq_q;
  assign bus.irq_lvl = irql_q;
  assign bus.dma_req = ~in_q & dmae_q;
  assign bus.vram_grp = hid_q[RRB_V_GRP_LSB +: 2];
  assign bus.vram_bits = hid_q[RRB_V_DSFCAS:0];
  assign bus.vram_locked = vs_q[1];
endmodule

// ===== rrb_checker.sv
// Interface assertions for the resource register bank link
`timescale 1ns/100ps
module rrb_checker import rrb_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register port
  input wire logic [3:0] req_addr,
  input wire logic req_bit,
  input wire logic req_we,
  input wire logic req_re,
  input wire logic [31:0] rdata,
  // Memory status and hidden register
  input wire logic posted_busy,
  input wire logic mem_done,
  input wire logic mem_core,
  input wire logic [1:0] mem_grp,
  input wire logic [1:0] vram_grp,
  input wire logic [4:0] vram_bits,
  input wire logic vram_locked
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic vid_hit;
  logic vid_wr;
  // Core access to the video group, word write of video control
  assign vid_hit = mem_done && mem_core && (mem_grp == vram_grp);
  assign vid_wr = req_we && (req_addr == RRB_A_VRAM) && !req_bit;
  property p_rd_gap;
    !req_re |=> rdata == 32'h0;
  endproperty
  a_rd_gap: assert property (p_rd_gap)
    else $error("read data without read");
  property p_unmapped;
    req_re && (req_addr > RRB_A_PINSEL) |=> rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_vram_hi;
    req_re && (req_addr == RRB_A_VRAM) && !req_bit |=> rdata[31:7] == 25'h0;
  endproperty
  a_vram_hi: assert property (p_vram_hi)
    else $error("video control upper bits not zero");
  property p_bit_hi;
    req_re && req_bit && (req_addr > RRB_A_BIT_LAST) |=> rdata == 32'h0;
  endproperty
  a_bit_hi: assert property (p_bit_hi)
    else $error("bit read of word-only register not zero");
  property p_lock_hold;
    vram_locked && !vid_hit |=> vram_locked;
  endproperty
  a_lock_hold: assert property (p_lock_hold)
    else $error("hidden register unlocked without access");
  property p_hid_stable;
    vram_locked && !vid_hit |=> $stable({vram_grp, vram_bits});
  endproperty
  a_hid_stable: assert property (p_hid_stable)
    else $error("locked hidden register changed");
  property p_lock_now;
    vid_wr && !vram_locked ##1 !posted_busy |=> vram_locked;
  endproperty
  a_lock_now: assert property (p_lock_now)
    else $error("unlocked write not copied");
  property p_lock_wait;
    vid_wr && !vram_locked ##1 posted_busy && !vram_locked |=> !vram_locked;
  endproperty
  a_lock_wait: assert property (p_lock_wait)
    else $error("copy did not wait for posted write");
  property p_reset;
    $rose(resetn) |-> (vram_grp == 2'h3) && (vram_bits == 5'h00);
  endproperty
  a_reset: assert property (p_reset)
    else $error("hidden register reset value wrong");
endmodule

// ===== tb_top.sv
// Self-checking bench joining both ends of the resource register bank
`timescale 1ns/100ps
module tb_top;
  logic clk = 1'b0;
  logic resetn, usr_bit, usr_we, usr_re, usr_refused, usr_bus_busy;
  logic usr_sw_int, usr_vec_exec, usr_reti, usr_dma_xfer, usr_posted_busy;
  logic usr_mem_done, usr_mem_core, usr_irq_req, ras_n, cas_n, ad_oe;
  logic [3:0] usr_addr;
  logic [2:0] usr_idx, usr_sw_int_lvl, usr_vec_lvl, usr_dma_ch, usr_irq_lvl;
  logic [31:0] usr_wdata, usr_rdata;
  logic [7:0] usr_vpu_consume, usr_dma_ack, usr_dma_req, in_pins;
  logic [7:0] ad_in, ad_drv, ad_out, out_pins;
  logic [9:0] usr_dma_addr;
  logic [1:0] usr_mem_grp;
  int miscompares = 0;
  int num_checks = 0;
  // Rows: index, written byte, expected read byte
  logic [19:0] rows [8] = '{20'h3A5A5, 20'h40000, 20'h13C3C, 20'h28181,
    20'h60F0F, 20'hC1200, 20'h10000, 20'h20000};
  // Clock, shared low address/data wire, both ends and checker
  always #10 clk = ~clk;
  assign ad_in = ad_oe ? ad_out : ad_drv;
  rrb_if ifc();
  rrb_device rrb_device_inst (.clk, .resetn, .in_pins, .ras_n, .cas_n,
    .ad_in, .ad_out, .ad_oe, .out_pins, .bus(ifc.dev));
  rrb_host rrb_host_inst (.clk, .resetn, .usr_addr, .usr_bit, .usr_idx,
    .usr_wdata, .usr_we, .usr_re, .usr_rdata, .usr_refused, .usr_bus_busy,
    .usr_vpu_consume, .usr_dma_ack, .usr_sw_int, .usr_sw_int_lvl,
    .usr_vec_exec, .usr_vec_lvl, .usr_reti, .usr_dma_xfer, .usr_dma_ch,
    .usr_dma_addr, .usr_posted_busy, .usr_mem_done, .usr_mem_core,
    .usr_mem_grp, .usr_irq_req, .usr_irq_lvl, .usr_dma_req, .bus(ifc.host));
  rrb_checker rrb_checker_inst (.clk, .resetn, .req_addr(ifc.req_addr),
    .req_bit(ifc.req_bit), .req_we(ifc.req_we), .req_re(ifc.req_re),
    .rdata(ifc.rdata), .posted_busy(ifc.posted_busy),
    .mem_done(ifc.mem_done), .mem_core(ifc.mem_core),
    .mem_grp(ifc.mem_grp), .vram_grp(ifc.vram_grp),
    .vram_bits(ifc.vram_bits), .vram_locked(ifc.vram_locked));
  // Clock edge helper
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Compare of one result
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One-cycle register write
  task automatic put(input logic [3:0] a, input logic b, input logic [2:0] i,
    input logic [31:0] d);
    tick(1);
    {usr_addr, usr_bit, usr_idx, usr_wdata, usr_we} <= {a, b, i, d, 1'b1};
    tick(1);
    usr_we <= 1'b0;
  endtask
  // One-cycle register read, data compared in the following cycle
  task automatic get(input logic [3:0] a, input logic b, input logic [2:0] i,
    input logic [31:0] exp);
    tick(1);
    {usr_addr, usr_bit, usr_idx, usr_re} <= {a, b, i, 1'b1};
    tick(1);
    usr_re <= 1'b0;
    #1 chk(usr_rdata, exp);
  endtask
  // One core or channel memory access completion
  task automatic mem(input logic c, input logic [1:0] g);
    tick(1);
    {usr_mem_core, usr_mem_grp, usr_mem_done} <= {c, g, 1'b1};
    tick(1);
    usr_mem_done <= 1'b0;
  endtask
  // Bounded wait for the hidden register lock
  task automatic wlock();
    int k;
    for (k = 0; k < 20 && ifc.vram_locked !== 1'b1; k++)
      tick(1);
    if (k == 20)
    begin
      miscompares++;
      conclude();
    end
  endtask
  // Counts and verdict
  task automatic conclude();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    {usr_addr, usr_bit, usr_idx, usr_wdata, usr_we, usr_re} = '0;
    {usr_bus_busy, usr_vpu_consume, usr_dma_ack, usr_sw_int} = '0;
    {usr_sw_int_lvl, usr_vec_exec, usr_vec_lvl, usr_reti, usr_dma_xfer} = '0;
    {usr_dma_ch, usr_dma_addr, usr_posted_busy, usr_mem_done} = '0;
    {usr_mem_core, usr_mem_grp, resetn, ad_drv} = '0;
    {in_pins, ras_n, cas_n} = '1;
    tick(8);
    resetn <= 1'b1;
    get(4'h7, 1'b0, 3'h0, 32'h60);
    foreach (rows[n])
    begin
      put(rows[n][19:16], 1'b0, 3'h0, {24'h0, rows[n][15:8]});
      get(rows[n][19:16], 1'b0, 3'h0, {24'h0, rows[n][7:0]});
    end
    put(4'h3, 1'b1, 3'h1, 32'h1);
    put(4'h3, 1'b1, 3'h7, 32'h0);
    get(4'h3, 1'b0, 3'h0, 32'h27);
    chk({ad_oe, out_pins, ad_out}, {1'b1, 16'h2727});
    get(4'h8, 1'b1, 3'h0, 32'h0);
    // Latch ignores AD with column low, samples it with column high
    tick(1);
    {ras_n, cas_n, ad_drv} <= {1'b0, 1'b0, 8'hFE};
    get(4'h0, 1'b0, 3'h0, 32'hFF);
    chk(ad_oe, 32'h0);
    cas_n <= 1'b1;
    tick(2);
    {ras_n, ad_drv} <= {1'b1, 8'hFF};
    get(4'h0, 1'b0, 3'h0, 32'hFE);
    usr_vpu_consume <= 8'h01;
    tick(1);
    usr_vpu_consume <= 8'h00;
    get(4'h0, 1'b0, 3'h0, 32'hFF);
    put(4'h8, 1'b0, 3'h0, 32'h1);
    in_pins <= 8'hF7;
    tick(2);
    in_pins <= 8'hFF;
    get(4'h0, 1'b0, 3'h0, 32'hF7);
    put(4'h0, 1'b1, 3'h3, 32'h1);
    get(4'h0, 1'b0, 3'h0, 32'hFF);
    // Enabled zero bit raises, vector moves it, return clears top in-service bit
    put(4'h4, 1'b0, 3'h0, 32'h1);
    in_pins <= 8'hFE;
    tick(2);
    in_pins <= 8'hFF;
    tick(3);
    get(4'h1, 1'b0, 3'h0, 32'h1);
    chk({usr_irq_req, usr_irq_lvl}, 32'h8);
    get(4'h0, 1'b0, 3'h0, 32'hFF);
    usr_vec_exec <= 1'b1;
    tick(1);
    usr_vec_exec <= 1'b0;
    get(4'h1, 1'b0, 3'h0, 32'h0);
    get(4'h2, 1'b0, 3'h0, 32'h1);
    in_pins <= 8'hFE;
    tick(2);
    in_pins <= 8'hFF;
    tick(2);
    get(4'h0, 1'b0, 3'h0, 32'hFF);
    put(4'h4, 1'b0, 3'h0, 32'h0);
    put(4'h1, 1'b0, 3'h0, 32'h0);
    put(4'h2, 1'b0, 3'h0, 32'h24);
    usr_reti <= 1'b1;
    tick(1);
    usr_reti <= 1'b0;
    get(4'h2, 1'b0, 3'h0, 32'h20);
    put(4'h2, 1'b0, 3'h0, 32'h0);
    {usr_sw_int, usr_sw_int_lvl} <= 4'hE;
    tick(1);
    usr_sw_int <= 1'b0;
    get(4'h1, 1'b0, 3'h0, 32'h40);
    put(4'h1, 1'b0, 3'h0, 32'h28);
    tick(2);
    #1 chk({usr_irq_req, usr_irq_lvl}, 32'hB);
    put(4'h1, 1'b0, 3'h0, 32'h0);
    // Channel request, recognition and page-end disable
    put(4'h4, 1'b0, 3'h0, 32'h2);
    put(4'h5, 1'b0, 3'h0, 32'h2);
    in_pins <= 8'hFD;
    tick(2);
    in_pins <= 8'hFF;
    tick(1);
    #1 chk(usr_dma_req, 32'h2);
    get(4'h1, 1'b0, 3'h0, 32'h0);
    usr_dma_ack <= 8'h02;
    tick(1);
    usr_dma_ack <= 8'h00;
    #1 chk(usr_dma_req, 32'h0);
    {usr_dma_xfer, usr_dma_ch, usr_dma_addr} <= {1'b1, 3'h1, 10'h3FE};
    tick(1);
    usr_dma_xfer <= 1'b0;
    get(4'h5, 1'b0, 3'h0, 32'h2);
    {usr_dma_xfer, usr_dma_addr} <= {1'b1, 10'h3FF};
    tick(1);
    usr_dma_xfer <= 1'b0;
    get(4'h5, 1'b0, 3'h0, 32'h0);
    // Video staging behind a posted write, then a locked rewrite
    usr_posted_busy <= 1'b1;
    put(4'h7, 1'b0, 3'h0, 32'h3F);
    tick(2);
    #1 chk(ifc.vram_locked, 32'h0);
    usr_posted_busy <= 1'b0;
    wlock();
    #1 chk({ifc.vram_grp, ifc.vram_bits}, 32'h3F);
    get(4'h7, 1'b0, 3'h0, 32'h30);
    put(4'h7, 1'b0, 3'h0, 32'h5E);
    mem(1'b1, 2'h0);
    mem(1'b0, 2'h1);
    tick(2);
    #1 chk({ifc.vram_grp, ifc.vram_bits}, 32'h3F);
    mem(1'b1, 2'h1);
    tick(2);
    #1 chk({ifc.vram_grp, ifc.vram_bits}, 32'h5E);
    get(4'h7, 1'b0, 3'h0, 32'h50);
    usr_bus_busy <= 1'b1;
    put(4'h7, 1'b0, 3'h0, 32'h0);
    #1 chk(usr_refused, 32'h1);
    usr_bus_busy <= 1'b0;
    get(4'h7, 1'b0, 3'h0, 32'h50);
    // Unlocking access, then an unlocked write with no posted write
    mem(1'b1, 2'h2);
    #1 chk(ifc.vram_locked, 32'h0);
    put(4'h7, 1'b0, 3'h0, 32'h2B);
    tick(2);
    #1 chk({ifc.vram_locked, ifc.vram_grp, ifc.vram_bits}, 32'hAB);
    get(4'h7, 1'b0, 3'h0, 32'h20);
    // Mid-run reset restores video control and latch
    resetn <= 1'b0;
    tick(2);
    resetn <= 1'b1;
    get(4'h7, 1'b0, 3'h0, 32'h60);
    get(4'h0, 1'b0, 3'h0, 32'hFF);
    conclude();
  end
endmodule
